// ---- rtl/cidle_demote.sv ----
`timescale 1ns/1ps
// Per-core auto-demotion: residency history and interrupt rate tracking
module cidle_demote
	import cidle_pkg::*;
#(
	parameter int CNT_W = 16
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst,
	// Policy
	input wire logic i_demote_en,
	input wire logic i_rate_en,
	input wire logic [CNT_W-1:0] i_res_thresh,
	input wire logic [CNT_W-1:0] i_rate_thresh,
	// Observed activity
	input wire logic i_in_deep,
	input wire logic i_in_idle,
	input wire logic i_intr,
	// Verdict
	output logic o_allow_deep,
	output logic o_rate_high
);
	typedef struct packed {
		logic [CNT_W-1:0] res;
		logic [CNT_W-1:0] win;
		logic [CNT_W-1:0] irq;
		logic rate_high;
		logic history_ok;
	} dem_s;

	localparam logic [CNT_W-1:0] WIN_LAST = CNT_W'(RATE_WINDOW_CYC - 1);

	dem_s st_reg;
	dem_s st_next;

	////////////////////////////////////////////////////////////////////////////
	// Residency counts idle cycles; rate counts interrupts per window
	always_comb begin
		st_next = st_reg;
		if (i_in_idle && st_reg.res != {CNT_W{1'b1}}) begin
			st_next.res = st_reg.res + 1'b1;
		end
		if (st_reg.res >= i_res_thresh) begin
			st_next.history_ok = 1'b1;
		end
		if (i_in_deep && !st_reg.history_ok) begin
			st_next.res = '0;
		end
		if (i_intr && st_reg.irq != {CNT_W{1'b1}}) begin
			st_next.irq = st_reg.irq + 1'b1;
		end
		if (st_reg.win == WIN_LAST) begin
			st_next.win = '0;
			st_next.irq = '0;
			st_next.rate_high = (st_reg.irq >= i_rate_thresh);
		end else begin
			st_next.win = st_reg.win + 1'b1;
		end
		if (!i_demote_en) begin
			st_next.history_ok = 1'b0;
			st_next.res = '0;
		end
	end

	// State register
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_allow_deep = !i_demote_en || st_reg.history_ok;
	assign o_rate_high = i_demote_en && i_rate_en && st_reg.rate_high;
endmodule // cidle_demote

// ---- rtl/cidle_thread.sv ----
`timescale 1ns/1ps
// Per-thread idle state tracker with wake handling
module cidle_thread
	import cidle_pkg::*;
(
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst,
	// Requests
	input wire logic i_req,
	input wire cstate_e i_req_state,
	input wire logic i_req_monitor,
	input wire logic i_req_timed,
	input wire logic i_req_break_masked,
	// Wake sources
	input wire logic i_intr,
	input wire logic i_intr_masked,
	input wire logic i_monitor_hit,
	input wire logic i_deadline,
	// State
	output cstate_e o_state,
	output logic o_wake
);
	typedef struct packed {
		cstate_e state;
		logic monitor;
		logic timed;
		logic break_masked;
		logic wake;
	} thr_s;

	thr_s st_reg;
	thr_s st_next;
	logic wake_any;

	////////////////////////////////////////////////////////////////////////////
	// Next state: any wake returns to active first
	always_comb begin
		st_next = st_reg;
		st_next.wake = 1'b0;
		wake_any = (i_intr && (!i_intr_masked || st_reg.break_masked)) ||
			(st_reg.monitor && i_monitor_hit) || (st_reg.timed && i_deadline);
		if (st_reg.state != CST_C0) begin
			if (wake_any) begin
				st_next.state = CST_C0;
				st_next.monitor = 1'b0;
				st_next.timed = 1'b0;
				st_next.break_masked = 1'b0;
				st_next.wake = 1'b1;
			end
		end else if (i_req) begin
			// New idle requests are accepted only from active
			st_next.state = i_req_state;
			st_next.monitor = i_req_monitor;
			st_next.timed = i_req_timed;
			st_next.break_masked = i_req_break_masked;
		end
	end

	// State register
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			st_reg <= '{state: CST_C0, monitor: 1'b0, timed: 1'b0, break_masked: 1'b0, wake: 1'b0};
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_state = st_reg.state;
	assign o_wake = st_reg.wake;
endmodule // cidle_thread

// ---- rtl/core_idle_state_resolver.sv ----
`timescale 1ns/1ps
// Core idle state resolver: thread requests to core state, legacy trap, demotion, memory power-down
module core_idle_state_resolver
	import cidle_pkg::*;
#(
	parameter int CORES = 2,
	parameter int THREADS = 2,
	parameter int CNT_W = 16
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst,
	// Register port
	input wire logic [3:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	// Wait and halt requests, per thread
	input wire logic [CORES*THREADS-1:0] i_wait_req,
	input wire logic [CORES*THREADS*3-1:0] i_wait_state,
	input wire logic [CORES*THREADS*4-1:0] i_wait_substate,
	input wire logic [CORES*THREADS-1:0] i_wait_monitor,
	input wire logic [CORES*THREADS-1:0] i_wait_timed,
	input wire logic [CORES*THREADS-1:0] i_wait_break_masked,
	// Legacy idle level reads, per thread
	input wire logic [CORES*THREADS-1:0] i_legacy_idle_level_read,
	input wire logic [CORES*THREADS*16-1:0] i_legacy_addr,
	output logic [CORES*THREADS-1:0] o_legacy_trapped,
	output logic [CORES*THREADS-1:0] o_legacy_passthru,
	// Wake sources
	input wire logic [CORES*THREADS-1:0] i_intr_thread,
	input wire logic [CORES*THREADS-1:0] i_intr_masked,
	input wire logic i_intr_pkg,
	input wire logic [CORES*THREADS-1:0] i_monitor_hit,
	input wire logic [CORES*THREADS-1:0] i_deadline,
	// Resolved core state, per-thread states and per-core power actions
	output logic [CORES*3-1:0] o_core_state,
	output logic [CORES*THREADS*3-1:0] o_thread_state,
	output logic [CORES*THREADS*4-1:0] o_thread_substate,
	output logic [CORES-1:0] o_exec_stop,
	output logic [CORES-1:0] o_clk_gate,
	output logic [CORES-1:0] o_min_vf,
	output logic [CORES-1:0] o_cache_flush,
	output logic [CORES-1:0] o_state_save,
	output logic [CORES-1:0] o_volt_reduce,
	// Memory controller
	input wire logic i_mem_banks_open,
	output logic o_mem_cke,
	output logic o_mem_self_refresh
);
	localparam int NT = CORES * THREADS;

	typedef struct packed {
		logic [31:0] cfg;
		logic [31:0] trap;
		logic [31:0] res;
		mem_pd_e mem_mode;
		logic [31:0] rdata;
		logic [CORES*3-1:0] core;
		logic [NT*4-1:0] sub;
		logic [NT-1:0] trapped;
		logic [NT-1:0] passthru;
	} top_s;

	top_s st_reg;
	top_s st_next;

	// Thread request path after legacy conversion
	logic [NT-1:0] req;
	cstate_e req_state [NT];
	logic [NT-1:0] req_mon;
	logic [NT-1:0] req_timed;
	logic [NT-1:0] req_brk;
	logic [NT-1:0] trap_hit;
	cstate_e thr_state [NT];
	logic [NT-1:0] thr_wake;
	logic [NT-1:0] thr_intr;
	logic [CORES-1:0] allow_deep;
	logic [CORES-1:0] rate_high;
	cstate_e core_raw [CORES];

	////////////////////////////////////////////////////////////////////////////
	// Legacy trap decode and request merge
	always_comb begin
		logic [15:0] base;
		logic [15:0] off;
		logic [2:0] len;
		base = st_reg.trap[TRAP_BASE_LSB +: 16];
		len = st_reg.trap[TRAP_LEN_LSB +: 3];
		off = 16'h0;
		for (int t = 0; t < NT; t++) begin
			off = i_legacy_addr[t*16 +: 16] - base;
			trap_hit[t] = i_legacy_idle_level_read[t] && st_reg.cfg[CFG_IO_REDIRECT_EN_BIT] &&
				(i_legacy_addr[t*16 +: 16] >= base) && (off < {13'h0, len});
			req[t] = i_wait_req[t] || trap_hit[t];
			req_mon[t] = i_wait_req[t] && i_wait_monitor[t];
			req_timed[t] = i_wait_req[t] && i_wait_timed[t];
			req_brk[t] = i_wait_req[t] ? i_wait_break_masked[t] : st_reg.cfg[CFG_BREAK_ON_MASKED_BIT];
			if (i_wait_req[t]) begin
				req_state[t] = cstate_e'(i_wait_state[t*3 +: 3]);
			end else if (off == 16'h0) begin
				req_state[t] = CST_C1;
			end else if (off == 16'h1) begin
				req_state[t] = CST_C6;
			end else if (off == 16'h2) begin
				req_state[t] = CST_C8;
			end else begin
				req_state[t] = CST_C10;
			end
			// Out-of-range encodings clamp to the deepest state
			if (req_state[t] > CST_C10) begin
				req_state[t] = CST_C10;
			end
			// Targeted interrupt plus package-wide interrupt
			thr_intr[t] = i_intr_thread[t] || i_intr_pkg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Per-thread trackers
	for (genvar t = 0; t < NT; t++) begin : g_thr
		cidle_thread u_thread (
			.i_mclk(i_mclk),
			.i_rst(i_rst),
			.i_req(req[t]),
			.i_req_state(req_state[t]),
			.i_req_monitor(req_mon[t]),
			.i_req_timed(req_timed[t]),
			.i_req_break_masked(req_brk[t]),
			.i_intr(thr_intr[t]),
			.i_intr_masked(i_intr_masked[t]),
			.i_monitor_hit(i_monitor_hit[t]),
			.i_deadline(i_deadline[t]),
			.o_state(thr_state[t]),
			.o_wake(thr_wake[t])
		);
	end

	////////////////////////////////////////////////////////////////////////////
	// Per-core demotion trackers
	for (genvar c = 0; c < CORES; c++) begin : g_dem
		cidle_demote #(
			.CNT_W(CNT_W)
		) u_demote (
			.i_mclk(i_mclk),
			.i_rst(i_rst),
			.i_demote_en(st_reg.cfg[CFG_DEMOTE_EN_BIT]),
			.i_rate_en(st_reg.cfg[CFG_RATE_DEMOTE_EN_BIT]),
			.i_res_thresh(st_reg.res[RES_THRESH_LSB +: CNT_W]),
			.i_rate_thresh(st_reg.res[RATE_THRESH_LSB +: CNT_W]),
			.i_in_deep(st_reg.core[c*3 +: 3] >= CST_C6),
			.i_in_idle(st_reg.core[c*3 +: 3] != CST_C0),
			.i_intr(|thr_intr[c*THREADS +: THREADS]),
			.o_allow_deep(allow_deep[c]),
			.o_rate_high(rate_high[c])
		);
	end

	////////////////////////////////////////////////////////////////////////////
	// Core resolution: minimum of thread states, then demotion
	always_comb begin
		cstate_e m;
		m = CST_C10;
		for (int c = 0; c < CORES; c++) begin
			m = CST_C10;
			for (int t = 0; t < THREADS; t++) begin
				if (thr_state[c*THREADS+t] < m) begin
					m = thr_state[c*THREADS+t];
				end
			end
			if (m >= CST_C6 && (!allow_deep[c] || rate_high[c])) begin
				m = CST_C1;
			end
			core_raw[c] = m;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Registers, core state update and read mux
	always_comb begin
		st_next = st_reg;
		st_next.rdata = 32'h0;
		st_next.trapped = trap_hit;
		st_next.passthru = i_legacy_idle_level_read & ~trap_hit;
		for (int c = 0; c < CORES; c++) begin
			// Idle to idle goes through C0 for one cycle
			if (st_reg.core[c*3 +: 3] != CST_C0 && core_raw[c] != CST_C0 &&
				st_reg.core[c*3 +: 3] != core_raw[c]) begin
				st_next.core[c*3 +: 3] = CST_C0;
			end else begin
				st_next.core[c*3 +: 3] = core_raw[c];
			end
		end
		for (int t = 0; t < NT; t++) begin
			if (trap_hit[t]) begin
				st_next.sub[t*4 +: 4] = 4'h0;
			end else if (i_wait_req[t]) begin
				st_next.sub[t*4 +: 4] = i_wait_substate[t*4 +: 4];
			end
		end
		if (i_wr) begin
			if (i_addr == ADDR_CONFIG_CONTROL) begin
				st_next.cfg = i_wdata;
			end else if (i_addr == ADDR_TRAP_RANGE) begin
				st_next.trap = i_wdata;
			end else if (i_addr == ADDR_MEM_CONTROL) begin
				st_next.mem_mode = mem_pd_e'(i_wdata[1:0]);
			end else if (i_addr == ADDR_RESIDENCY_CFG) begin
				st_next.res = i_wdata;
			end
		end
		if (i_rd) begin
			if (i_addr == ADDR_CONFIG_CONTROL) begin
				st_next.rdata = st_reg.cfg;
			end else if (i_addr == ADDR_TRAP_RANGE) begin
				st_next.rdata = st_reg.trap;
			end else if (i_addr == ADDR_CORE_STATUS) begin
				st_next.rdata = 32'(st_reg.core);
			end else if (i_addr == ADDR_MEM_CONTROL) begin
				st_next.rdata = {29'h0, i_mem_banks_open, st_reg.mem_mode};
			end else if (i_addr == ADDR_RESIDENCY_CFG) begin
				st_next.rdata = st_reg.res;
			end else begin
				st_next.rdata = 32'h0;
			end
		end
	end

	// State register
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			st_reg.cfg <= CFG_RESET_VALUE;
			st_reg.trap <= TRAP_RESET_VALUE;
			st_reg.res <= RES_RESET_VALUE;
			st_reg.mem_mode <= MEM_POWER_UP;
			st_reg.rdata <= 32'h0;
			st_reg.core <= '0;
			st_reg.sub <= '0;
			st_reg.trapped <= '0;
			st_reg.passthru <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Power actions driven only from resolved core state
	always_comb begin
		for (int c = 0; c < CORES; c++) begin
			o_exec_stop[c] = st_reg.core[c*3 +: 3] != CST_C0;
			o_clk_gate[c] = st_reg.core[c*3 +: 3] != CST_C0;
			o_min_vf[c] = st_reg.core[c*3 +: 3] >= CST_C1E;
			o_cache_flush[c] = st_reg.core[c*3 +: 3] >= CST_C6;
			o_state_save[c] = st_reg.core[c*3 +: 3] >= CST_C6;
			o_volt_reduce[c] = st_reg.core[c*3 +: 3] >= CST_C6;
		end
		for (int t = 0; t < NT; t++) begin
			o_thread_state[t*3 +: 3] = thr_state[t];
		end
	end

	// Memory controller clock enable and self-refresh
	always_comb begin
		o_mem_cke = 1'b1;
		o_mem_self_refresh = 1'b0;
		if (st_reg.mem_mode == MEM_SELF_REFRESH) begin
			o_mem_cke = 1'b0;
			o_mem_self_refresh = 1'b1;
		end else if (st_reg.mem_mode == MEM_ACTIVE_PD && i_mem_banks_open) begin
			o_mem_cke = 1'b0;
		end else if (st_reg.mem_mode == MEM_PRECHARGE_PD && !i_mem_banks_open) begin
			o_mem_cke = 1'b0;
		end
	end

	// Package C2 and C3 have no request encoding at all
	assign o_core_state = st_reg.core;
	assign o_thread_substate = st_reg.sub;
	assign o_legacy_trapped = st_reg.trapped;
	assign o_legacy_passthru = st_reg.passthru;
	assign o_rdata = st_reg.rdata;
endmodule // core_idle_state_resolver

// ---- shared/cidle_pkg.sv ----
// Constants, encodings and register map of the core idle state resolver
package cidle_pkg;
	// Idle state encodings, numerically ordered (lower is shallower)
	typedef enum logic [2:0] {
		CST_C0 = 3'b000,
		CST_C1 = 3'b001,
		CST_C1E = 3'b010,
		CST_C6 = 3'b011,
		CST_C8 = 3'b100,
		CST_C10 = 3'b101
	} cstate_e;

	// Memory controller power-down states
	typedef enum logic [1:0] {
		MEM_POWER_UP = 2'b00,
		MEM_PRECHARGE_PD = 2'b01,
		MEM_ACTIVE_PD = 2'b10,
		MEM_SELF_REFRESH = 2'b11
	} mem_pd_e;

	// Register offsets
	localparam logic [3:0] ADDR_CONFIG_CONTROL = 4'h0;
	localparam logic [3:0] ADDR_TRAP_RANGE = 4'h1;
	localparam logic [3:0] ADDR_CORE_STATUS = 4'h2;
	localparam logic [3:0] ADDR_MEM_CONTROL = 4'h3;
	localparam logic [3:0] ADDR_RESIDENCY_CFG = 4'h4;

	// Config control fields
	localparam int CFG_DEMOTE_EN_BIT = 0;
	localparam int CFG_RATE_DEMOTE_EN_BIT = 1;
	localparam int CFG_IO_REDIRECT_EN_BIT = 2;
	localparam int CFG_BREAK_ON_MASKED_BIT = 3;
	localparam logic [31:0] CFG_RESET_VALUE = 32'h0000_000c;

	// Trap range fields: base in [15:0], length (count of levels) in [18:16]
	localparam int TRAP_BASE_LSB = 0;
	localparam int TRAP_LEN_LSB = 16;
	localparam logic [31:0] TRAP_RESET_VALUE = 32'h0003_0000;

	// Residency and interrupt rate thresholds
	localparam int RES_THRESH_LSB = 0;
	localparam int RATE_THRESH_LSB = 16;
	localparam logic [31:0] RES_RESET_VALUE = 32'h0008_0040;

	// Interrupt rate sampling window
	localparam int RATE_WINDOW_US = 4;
	localparam int CLK_MHZ = 125;
	localparam int RATE_WINDOW_CYC = RATE_WINDOW_US * CLK_MHZ;
endpackage

// ---- test/cidle_thread_model.sv ----
`timescale 1ns/1ps
// Model of the hardware threads and wake sources
module cidle_thread_model
	import cidle_pkg::*;
#(
	parameter int NT = 4
) (
	// Clock
	input wire logic i_mclk,
	// Requests
	output logic [NT-1:0] o_wait_req = '0,
	output logic [NT*3-1:0] o_wait_state = '0,
	output logic [NT*4-1:0] o_wait_substate = '0,
	output logic [NT-1:0] o_wait_monitor = '0,
	output logic [NT-1:0] o_wait_timed = '0,
	output logic [NT-1:0] o_wait_break_masked = '0,
	output logic [NT-1:0] o_legacy_rd = '0,
	output logic [NT*16-1:0] o_legacy_addr = '0,
	// Wake sources
	output logic [NT-1:0] o_intr_thread = '0,
	output logic [NT-1:0] o_intr_masked = '0,
	output logic o_intr_pkg = 1'b0,
	output logic [NT-1:0] o_monitor_hit = '0,
	output logic [NT-1:0] o_deadline = '0
);
	////////////////////////////////////////////////////////////
	// Wait request pulse; state and substate scrambled once released, monitor and timed left set
	task automatic wait_req(input int t, input cstate_e s);
		@(posedge i_mclk);
		o_wait_req[t] <= 1'b1;
		o_wait_state[t*3+:3] <= s;
		o_wait_substate[t*4+:4] <= 4'h5;
		o_wait_monitor[t] <= 1'b1;
		o_wait_timed[t] <= 1'b1;
		@(posedge i_mclk);
		o_wait_req <= '0;
		o_wait_state <= ~o_wait_state;
		o_wait_substate <= ~o_wait_substate;
	endtask
	// Legacy idle level read pulse
	task automatic legacy(input int t, input logic [15:0] a);
		@(posedge i_mclk);
		o_legacy_rd[t] <= 1'b1;
		o_legacy_addr[t*16+:16] <= a;
		@(posedge i_mclk);
		o_legacy_rd <= '0;
		o_legacy_addr <= ~o_legacy_addr;
	endtask
	// Wake pulse: 0 irq, 1 monitor, 2 deadline, 3 package irq, 4 masked irq
	task automatic wake(input int t, input int k);
		@(posedge i_mclk);
		o_intr_thread[t] <= (k == 0 || k == 4);
		o_intr_masked[t] <= (k == 4);
		o_monitor_hit[t] <= (k == 1);
		o_deadline[t] <= (k == 2);
		o_intr_pkg <= (k == 3);
		@(posedge i_mclk);
		{o_intr_thread, o_intr_masked, o_monitor_hit, o_deadline, o_intr_pkg} <= '0;
	endtask
endmodule // cidle_thread_model

// ---- test/core_idle_state_resolver_properties.sv ----
`timescale 1ns/1ps
// Port checks of the core idle state resolver
module core_idle_state_resolver_properties
	import cidle_pkg::*;
#(
	parameter int CORES = 2,
	parameter int THREADS = 2
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst,
	// Watched ports
	input wire logic [CORES*THREADS-1:0] i_wait_req,
	input wire logic [CORES*THREADS*3-1:0] i_wait_state,
	input wire logic [CORES*THREADS-1:0] i_legacy_idle_level_read,
	input wire logic [CORES*THREADS-1:0] o_legacy_trapped,
	input wire logic [CORES*THREADS-1:0] o_legacy_passthru,
	input wire logic i_intr_pkg,
	input wire logic [CORES*3-1:0] o_core_state,
	input wire logic [CORES*THREADS*3-1:0] o_thread_state,
	input wire logic [CORES-1:0] o_exec_stop,
	input wire logic [CORES-1:0] o_clk_gate,
	input wire logic [CORES-1:0] o_min_vf,
	input wire logic [CORES-1:0] o_cache_flush,
	input wire logic [CORES-1:0] o_state_save,
	input wire logic [CORES-1:0] o_volt_reduce,
	input wire logic o_mem_cke,
	input wire logic o_mem_self_refresh
);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	////////////////////////////////////////////////////////////
	// Wake steps: threads first, cores one cycle later
	sequence s_threads_up;
		o_thread_state == '0;
	endsequence
	sequence s_cores_up;
		o_core_state == '0;
	endsequence
	a_pkg_wake_all: assert property (i_intr_pkg |=> s_threads_up ##1 s_cores_up)
		else $error("Package interrupt left a thread or core idle");
	a_active_core: assert property ((o_thread_state[2:0] == 3'h0 || o_thread_state[5:3] == 3'h0) |=> o_core_state[2:0] == 3'h0)
		else $error("Core idle while a thread was active");
	a_clock_gate: assert property (o_exec_stop == o_clk_gate && o_clk_gate[0] == (o_core_state[2:0] != 3'h0))
		else $error("Execution stop or clock gate out of step with core state");
	a_low_vf: assert property (o_min_vf[0] == (o_core_state[2:0] >= CST_C1E))
		else $error("Minimum operating point out of step with core state");
	a_deep_save: assert property (o_cache_flush[0] == (o_core_state[2:0] >= CST_C6) && o_state_save == o_cache_flush
		&& o_volt_reduce == o_cache_flush && o_volt_reduce[1] == (o_core_state[5:3] >= CST_C6))
		else $error("Flush or state save out of step with core state");
	a_via_active: assert property ((o_thread_state[2:0] != 3'h0) ##1 (o_thread_state[2:0] != $past(o_thread_state[2:0]))
		|-> o_thread_state[2:0] == 3'h0)
		else $error("Thread moved between idle states without active");
	a_req_taken: assert property (i_wait_req[0] && o_thread_state[2:0] == 3'h0 && !i_intr_pkg |=>
		o_thread_state[2:0] == (($past(i_wait_state[2:0]) > 3'h5) ? 3'h5 : $past(i_wait_state[2:0])))
		else $error("Thread request not taken in one cycle");
	a_trap_pulse: assert property ((o_legacy_trapped | o_legacy_passthru) == $past(i_legacy_idle_level_read)
		&& (o_legacy_trapped & o_legacy_passthru) == '0)
		else $error("Legacy read outcome pulse wrong");
	a_refresh_cke: assert property (o_mem_self_refresh |-> !o_mem_cke)
		else $error("Clock enable high in self refresh");
endmodule // core_idle_state_resolver_properties

bind core_idle_state_resolver core_idle_state_resolver_properties #(.CORES(CORES), .THREADS(THREADS)) props_u (
	.i_mclk, .i_rst, .i_wait_req, .i_wait_state, .i_legacy_idle_level_read, .o_legacy_trapped, .o_legacy_passthru,
	.i_intr_pkg, .o_core_state, .o_thread_state, .o_exec_stop, .o_clk_gate, .o_min_vf, .o_cache_flush,
	.o_state_save, .o_volt_reduce, .o_mem_cke, .o_mem_self_refresh
);

// ---- test/core_idle_state_resolver_tb.sv ----
`timescale 1ns/1ps
// Self-checking bench of the core idle state resolver
module core_idle_state_resolver_tb;
	import cidle_pkg::*;
	localparam int NT = 4;
	logic i_mclk = 1'b0;
	logic i_rst = 1'b1;
	logic [3:0] i_addr = '0;
	logic [31:0] i_wdata = '0;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic i_mem_banks_open = 1'b0;
	logic [31:0] o_rdata;
	logic [NT-1:0] i_wait_req, i_wait_monitor, i_wait_timed, i_wait_break_masked, i_legacy_idle_level_read;
	logic [NT-1:0] i_intr_thread, i_intr_masked, i_monitor_hit, i_deadline, o_legacy_trapped, o_legacy_passthru;
	logic [NT*3-1:0] i_wait_state, o_thread_state;
	logic [NT*4-1:0] i_wait_substate, o_thread_substate;
	logic [NT*16-1:0] i_legacy_addr;
	logic [5:0] o_core_state;
	logic i_intr_pkg, o_mem_cke, o_mem_self_refresh;
	cstate_e exp_th [NT] = '{default: CST_C0};
	logic dem = 1'b0;
	int err_count = 0;
	int num_checks = 0;
	int cycles = 0;
	////////////////////////////////////////////////////////////
	core_idle_state_resolver #(.CORES(2), .THREADS(2), .CNT_W(16)) dut_u (
		.i_mclk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
		.i_wait_req, .i_wait_state, .i_wait_substate, .i_wait_monitor, .i_wait_timed, .i_wait_break_masked,
		.i_legacy_idle_level_read, .i_legacy_addr, .o_legacy_trapped, .o_legacy_passthru,
		.i_intr_thread, .i_intr_masked, .i_intr_pkg, .i_monitor_hit, .i_deadline,
		.o_core_state, .o_thread_state, .o_thread_substate, .o_exec_stop(), .o_clk_gate(), .o_min_vf(),
		.o_cache_flush(), .o_state_save(), .o_volt_reduce(), .i_mem_banks_open, .o_mem_cke, .o_mem_self_refresh
	);
	cidle_thread_model #(.NT(NT)) pm_u (
		.i_mclk, .o_wait_req(i_wait_req), .o_wait_state(i_wait_state), .o_wait_substate(i_wait_substate),
		.o_wait_monitor(i_wait_monitor), .o_wait_timed(i_wait_timed), .o_wait_break_masked(i_wait_break_masked),
		.o_legacy_rd(i_legacy_idle_level_read), .o_legacy_addr(i_legacy_addr), .o_intr_thread(i_intr_thread),
		.o_intr_masked(i_intr_masked), .o_intr_pkg(i_intr_pkg), .o_monitor_hit(i_monitor_hit),
		.o_deadline(i_deadline)
	);
	// Clock and hang guard
	always #4 i_mclk = ~i_mclk;
	always @(posedge i_mclk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			err_count++;
			end_of_test();
		end
	end
	////////////////////////////////////////////////////////////
	// Expected core state: shallowest thread, deep held at C1 under demotion
	function automatic logic [2:0] core_exp(input int c);
		cstate_e m;
		m = (exp_th[2*c] < exp_th[2*c+1]) ? exp_th[2*c] : exp_th[2*c+1];
		return (dem && m >= CST_C6) ? 3'(CST_C1) : 3'(m);
	endfunction
	// Expected clock enable and self refresh per mode and bank condition
	function automatic logic [31:0] mem_exp(input int k);
		case (k % 4)
			1: return (k > 3) ? 32'h2 : 32'h0;
			2: return (k > 3) ? 32'h0 : 32'h2;
			3: return 32'h1;
			default: return 32'h2;
		endcase
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge i_mclk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_mclk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge i_mclk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		#1;
		chk(o_rdata, e);
	endtask
	// Thread, core and status register against the model
	task automatic check_all();
		repeat (3) @(posedge i_mclk);
		#1;
		for (int t = 0; t < NT; t++) chk(32'(o_thread_state[t*3+:3]), 32'(exp_th[t]));
		for (int c = 0; c < 2; c++) chk(32'(o_core_state[c*3+:3]), 32'(core_exp(c)));
		rd(ADDR_CORE_STATUS, 32'({core_exp(1), core_exp(0)}));
	endtask
	task automatic end_of_test();
		$display("Checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////
	initial begin : main
		int t;
		int k;
		void'($urandom(22));
		repeat (3) @(posedge i_mclk);
		i_rst <= 1'b0;
		// Reset values and an unmapped address
		rd(ADDR_CONFIG_CONTROL, CFG_RESET_VALUE);
		rd(ADDR_TRAP_RANGE, TRAP_RESET_VALUE);
		rd(ADDR_RESIDENCY_CFG, RES_RESET_VALUE);
		rd(4'hf, 32'h0);
		// Random requests and wakes; masked irq must not wake a wait
		for (int n = 0; n < 40; n++) begin
			t = $urandom_range(NT - 1);
			if (exp_th[t] == CST_C0) begin
				k = $urandom_range(5, 1);
				pm_u.wait_req(t, cstate_e'(k));
				exp_th[t] = cstate_e'(k);
			end else begin
				k = $urandom_range(4);
				pm_u.wake(t, k);
				if (k == 3) exp_th = '{default: CST_C0};
				else if (k != 4) exp_th[t] = CST_C0;
			end
			check_all();
		end
		// Legacy reads inside and just past a moved trap window
		pm_u.wake(0, 3);
		exp_th = '{default: CST_C0};
		wr(ADDR_TRAP_RANGE, 32'h0003_0400);
		for (k = 0; k < 4; k++) begin
			pm_u.legacy(1, 16'h0400 + 16'(k));
			#1;
			chk(32'({o_legacy_trapped[1], o_legacy_passthru[1]}), (k < 3) ? 32'h2 : 32'h1);
			if (k < 3) begin
				exp_th[1] = cstate_e'((k == 0) ? 1 : k + 2);
				check_all();
				chk(32'(o_thread_substate[7:4]), 32'h0);
				pm_u.wake(1, 4);
				exp_th[1] = CST_C0;
				check_all();
			end
		end
		// Demotion holds deep requests at C1 while residency is short
		wr(ADDR_RESIDENCY_CFG, 32'h0008_ffff);
		wr(ADDR_CONFIG_CONTROL, 32'h0000_000d);
		dem = 1'b1;
		pm_u.wait_req(0, CST_C6);
		pm_u.wait_req(1, CST_C10);
		exp_th[0] = CST_C6;
		exp_th[1] = CST_C10;
		check_all();
		pm_u.wake(2, 3);
		exp_th = '{default: CST_C0};
		check_all();
		// Memory power-down modes against the bank condition
		for (k = 0; k < 8; k++) begin
			wr(ADDR_MEM_CONTROL, 32'(k % 4));
			i_mem_banks_open <= (k > 3);
			@(posedge i_mclk);
			#1;
			chk(32'({o_mem_cke, o_mem_self_refresh}), mem_exp(k));
		end
		// Second reset with a thread idle
		pm_u.wait_req(2, CST_C8);
		@(posedge i_mclk);
		i_rst <= 1'b1;
		repeat (3) @(posedge i_mclk);
		i_rst <= 1'b0;
		exp_th = '{default: CST_C0};
		dem = 1'b0;
		rd(ADDR_CONFIG_CONTROL, CFG_RESET_VALUE);
		check_all();
		end_of_test();
	end
endmodule // core_idle_state_resolver_tb
